// [rtl/hpp_pkg.sv]
// shared constants, types and helpers for the host processor port
package hpp_pkg;

    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int LOW_ADDR_W = 9;

    // serial control word: read/write first, burst last
    localparam int CTRL_RW_BIT = 15;
    localparam int CTRL_FIELD_MSB = 14;
    localparam int CTRL_FIELD_LSB = 1;
    localparam int CTRL_BURST_BIT = 0;
    localparam int FIELD_UPPER_BIT = 12;

    // strap positions on the data bus
    localparam int STRAP_IDLE_BIT = 7;
    localparam int STRAP_PHASE_BIT = 6;
    localparam int STRAP_ORDER_BIT = 5;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;

    typedef enum logic [2:0] {
        SPI_CTRL0 = 3'b001,
        SPI_CTRL1 = 3'b010,
        SPI_DATA = 3'b100
    } hpp_spi_state_type;

    typedef struct packed {
        logic spiSel;
        logic busStyle;
        logic csN;
        logic rdN;
        logic wrN;
        logic dirLvl;
        logic dsN;
        logic [LOW_ADDR_W-1:0] addrLo;
        logic upper;
        logic [DATA_W-1:0] dIn;
        logic sclk;
        logic mosi;
    } hpp_pins_type;

    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } hpp_mem_req_type;

    typedef struct packed {
        hpp_pins_type sync1;
        hpp_pins_type sync2;
        logic prevSclk;
        logic prevCsN;
        logic prevWr;
        logic prevDs;
        logic [1:0] strapAge;
        logic strapDone;
        logic cpol;
        logic cpha;
        logic swap;
        hpp_spi_state_type spiState;
        logic [2:0] bitCnt;
        logic [DATA_W-1:0] rxShift;
        logic [DATA_W-1:0] ctrlHi;
        logic [DATA_W-1:0] txShift;
        logic spiRead;
        logic spiBurst;
        logic [ADDR_W-1:0] spiAddr;
        logic [DATA_W-1:0] dataOut;
        logic dataOe;
        logic misoOut;
        logic misoOe;
        logic intOut;
        logic intOe;
    } hpp_state_type;

    localparam hpp_pins_type PINS_IDLE = '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1, dsN: 1'b1,
                                           default: '0};

    localparam hpp_state_type STATE_RESET = '{sync1: PINS_IDLE, sync2: PINS_IDLE,
                                             prevCsN: 1'b1, prevWr: 1'b1, prevDs: 1'b1,
                                             spiState: SPI_CTRL0, default: '0};

    function automatic logic [DATA_W-1:0] rev8(input logic [DATA_W-1:0] v);
        logic [DATA_W-1:0] r;
        r = '0;
        for (int i = 0; i < DATA_W; i++) begin
            r[i] = v[DATA_W-1-i];
        end
        return r;
    endfunction

    function automatic logic [13:0] rev14(input logic [13:0] v);
        logic [13:0] r;
        r = '0;
        for (int i = 0; i < 14; i++) begin
            r[i] = v[13-i];
        end
        return r;
    endfunction

endpackage

// [rtl/hpp_reg_mem.sv]
// register space storage with registered read data
`timescale 1ns/1ps
module hpp_reg_mem #(
    parameter int AW = hpp_pkg::ADDR_W,
    parameter int DW = hpp_pkg::DATA_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // access
    input wire hpp_pkg::hpp_mem_req_type memReq,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge mclk) begin
        if (memReq.we) begin
            mem[memReq.addr] <= memReq.wdata;
        end
    end

    // read-during-write returns the old byte; the port never reads what it just wrote
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= mem[memReq.addr];
        end
    end
endmodule

// [rtl/hpp_top.sv]
// host processor port: parallel bus or serial slave access to the register space
`timescale 1ns/1ps
module hpp_top #(
    parameter int IRQ_W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // mode pins
    input wire logic spiSelect,
    input wire logic busStyleSelect,
    // parallel bus
    input wire logic chipSelectN,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    input wire logic directionLevel,
    input wire logic dataStrobeN,
    input wire logic [hpp_pkg::LOW_ADDR_W-1:0] addrLow,
    input wire logic upperAddressBit,
    input wire logic [hpp_pkg::DATA_W-1:0] dataIn,
    output logic [hpp_pkg::DATA_W-1:0] dataOut,
    output logic dataOe,
    // serial link
    input wire logic serialClock,
    input wire logic mosi,
    output logic misoOut,
    output logic misoOe,
    // interrupt sources from the device core, same clock
    input wire logic [IRQ_W-1:0] irqSources,
    input wire logic [IRQ_W-1:0] irqEnable,
    output logic interruptOutNOut,
    output logic interruptOutNOe
);
    hpp_pkg::hpp_state_type st_reg;
    hpp_pkg::hpp_state_type st_next;
    hpp_pkg::hpp_pins_type pins;
    hpp_pkg::hpp_pins_type p;
    hpp_pkg::hpp_mem_req_type memReq;
    logic [hpp_pkg::DATA_W-1:0] memRdata;
    logic sclkRise;
    logic sclkFall;
    logic sampleEdge;
    logic shiftEdge;
    logic spiActive;
    logic byteDone;
    logic [hpp_pkg::DATA_W-1:0] rxByte;
    logic [15:0] ctrlWord;
    logic [13:0] field;
    logic readActive;
    logic writeCommit;
    logic irqPending;

    assign pins = '{spiSel: spiSelect, busStyle: busStyleSelect, csN: chipSelectN,
                    rdN: readStrobeN, wrN: writeStrobeN, dirLvl: directionLevel,
                    dsN: dataStrobeN, addrLo: addrLow, upper: upperAddressBit,
                    dIn: dataIn, sclk: serialClock, mosi: mosi};

    hpp_reg_mem #(
        .AW(hpp_pkg::ADDR_W),
        .DW(hpp_pkg::DATA_W)
    ) u_mem (
        .mclk(mclk),
        .rst(rst),
        .memReq(memReq),
        .rdata(memRdata)
    );

    always_comb begin
        st_next = st_reg;
        p = st_reg.sync2;
        // second stage is the only reader of the first
        st_next.sync1 = pins;
        st_next.sync2 = st_reg.sync1;
        st_next.prevSclk = p.sclk;
        st_next.prevCsN = p.csN;
        st_next.prevWr = p.wrN;
        st_next.prevDs = p.dsN;

        // straps are caught once the synchronisers hold post-reset pin levels
        if (!st_reg.strapDone) begin
            st_next.strapAge = st_reg.strapAge + 2'h1;
            if (st_reg.strapAge == hpp_pkg::STRAP_SETTLE) begin
                st_next.strapDone = 1'b1;
                st_next.cpol = p.dIn[hpp_pkg::STRAP_IDLE_BIT];
                st_next.cpha = p.dIn[hpp_pkg::STRAP_PHASE_BIT];
                st_next.swap = p.dIn[hpp_pkg::STRAP_ORDER_BIT];
            end
        end

        // the master makes the clock; edges are found by oversampling it
        sclkRise = p.sclk & ~st_reg.prevSclk;
        sclkFall = ~p.sclk & st_reg.prevSclk;
        sampleEdge = (st_reg.cpol == st_reg.cpha) ? sclkRise : sclkFall;
        shiftEdge = (st_reg.cpol == st_reg.cpha) ? sclkFall : sclkRise;
        spiActive = p.spiSel & ~p.csN & st_reg.strapDone;
        byteDone = spiActive & sampleEdge & (st_reg.bitCnt == hpp_pkg::BIT_LAST);
        rxByte = {st_reg.rxShift[hpp_pkg::DATA_W-2:0], p.mosi};
        ctrlWord = {st_reg.ctrlHi, rxByte};
        field = ctrlWord[hpp_pkg::CTRL_FIELD_MSB:hpp_pkg::CTRL_FIELD_LSB];
        if (st_reg.swap) begin
            field = hpp_pkg::rev14(field);
        end

        // parallel port, used only when the serial select is low
        if (p.busStyle) begin
            readActive = ~p.csN & ~p.dsN & p.dirLvl;
            writeCommit = p.dsN & ~st_reg.prevDs & ~st_reg.prevCsN & ~p.dirLvl;
        end else begin
            readActive = ~p.csN & ~p.rdN;
            writeCommit = p.wrN & ~st_reg.prevWr & ~st_reg.prevCsN;
        end
        readActive = readActive & ~p.spiSel;
        writeCommit = writeCommit & ~p.spiSel;

        memReq.we = 1'b0;
        memReq.addr = p.spiSel ? st_reg.spiAddr : {p.upper, p.addrLo};
        memReq.wdata = p.dIn;
        if (writeCommit) begin
            memReq.we = 1'b1;
        end
        st_next.dataOut = memRdata;
        st_next.dataOe = readActive;

        // serial engine
        if (!spiActive) begin
            st_next.spiState = hpp_pkg::SPI_CTRL0;
            st_next.bitCnt = hpp_pkg::BIT_FIRST;
        end else begin
            if (shiftEdge) begin
                if (st_reg.bitCnt == hpp_pkg::BIT_FIRST) begin
                    // byte boundary: load the next byte, read data only in a read slot
                    if (st_reg.spiState == hpp_pkg::SPI_DATA && st_reg.spiRead) begin
                        st_next.txShift = st_reg.swap ? hpp_pkg::rev8(memRdata) : memRdata;
                    end else begin
                        st_next.txShift = '0;
                    end
                    st_next.misoOut = st_next.txShift[hpp_pkg::DATA_W-1];
                end else begin
                    st_next.txShift = {st_reg.txShift[hpp_pkg::DATA_W-2:0], 1'b0};
                    st_next.misoOut = st_reg.txShift[hpp_pkg::DATA_W-2];
                end
            end
            if (sampleEdge) begin
                st_next.rxShift = rxByte;
                st_next.bitCnt = st_reg.bitCnt + 3'h1;
            end
            if (byteDone) begin
                case (st_reg.spiState)
                    hpp_pkg::SPI_CTRL0: begin
                        st_next.ctrlHi = rxByte;
                        st_next.spiState = hpp_pkg::SPI_CTRL1;
                    end
                    hpp_pkg::SPI_CTRL1: begin
                        st_next.spiRead = ctrlWord[hpp_pkg::CTRL_RW_BIT];
                        st_next.spiBurst = ctrlWord[hpp_pkg::CTRL_BURST_BIT];
                        st_next.spiAddr = {field[hpp_pkg::FIELD_UPPER_BIT],
                                           field[hpp_pkg::LOW_ADDR_W-1:0]};
                        st_next.spiState = hpp_pkg::SPI_DATA;
                    end
                    hpp_pkg::SPI_DATA: begin
                        if (!st_reg.spiRead) begin
                            memReq.we = 1'b1;
                            memReq.addr = st_reg.spiAddr;
                            memReq.wdata = st_reg.swap ? hpp_pkg::rev8(rxByte) : rxByte;
                        end
                        if (st_reg.spiBurst) begin
                            // no more control bytes, step to the next register
                            st_next.spiAddr = st_reg.spiAddr + 10'h001;
                        end else begin
                            st_next.spiState = hpp_pkg::SPI_CTRL0;
                        end
                    end
                    default: begin
                        st_next.spiState = hpp_pkg::SPI_CTRL0;
                    end
                endcase
            end
        end
        st_next.misoOe = spiActive;

        // open drain: the pad level stays low, only the enable moves
        irqPending = |(irqSources & irqEnable);
        st_next.intOut = 1'b0;
        st_next.intOe = irqPending;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg <= hpp_pkg::STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dataOut = st_reg.dataOut;
    assign dataOe = st_reg.dataOe;
    assign misoOut = st_reg.misoOut;
    assign misoOe = st_reg.misoOe;
    assign interruptOutNOut = st_reg.intOut;
    assign interruptOutNOe = st_reg.intOe;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    split_read_drive_a: assert property (
        (!p.spiSel && !p.busStyle && !p.csN && !p.rdN) |=> dataOe
    ) else $error("separate-strobe read did not drive the data bus");

    strobe_read_drive_a: assert property (
        (!p.spiSel && p.busStyle && !p.csN && !p.dsN && p.dirLvl) |=> dataOe
    ) else $error("data-strobe read did not drive the data bus");

    strobe_write_dir_a: assert property (
        (p.busStyle && !p.spiSel && memReq.we) |-> !p.dirLvl && $rose(p.dsN)
    ) else $error("data-strobe write without write direction");

    // compared against the raw pins two edges back, not against the synchronised copy
    parallel_addr_a: assert property (
        (!p.spiSel && memReq.we)
        |-> memReq.addr == {$past(upperAddressBit, 2), $past(addrLow, 2)}
            && memReq.wdata == $past(dataIn, 2)
    ) else $error("parallel write to wrong address or with wrong data");

    unselected_write_a: assert property (
        (!p.spiSel && $past(chipSelectN, 3)) |-> !memReq.we
    ) else $error("parallel write taken without chip select");

    serial_quiet_bus_a: assert property (
        (p.spiSel && $past(p.spiSel)) |=> !dataOe
    ) else $error("data bus driven in serial mode");

    irq_follow_a: assert property (
        (|(irqSources & irqEnable)) |=> interruptOutNOe && !interruptOutNOut
    ) else $error("interrupt not asserted for enabled source");

    burst_step_a: assert property (
        (byteDone && st_reg.spiState == hpp_pkg::SPI_DATA && st_reg.spiBurst)
        |=> st_reg.spiAddr == $past(st_reg.spiAddr) + 10'h001
            && st_reg.spiState == hpp_pkg::SPI_DATA
    ) else $error("burst did not step the address");

    single_back_ctrl_a: assert property (
        (byteDone && st_reg.spiState == hpp_pkg::SPI_DATA && !st_reg.spiBurst)
        |=> st_reg.spiState == hpp_pkg::SPI_CTRL0
    ) else $error("single access did not return to control bytes");

    reselect_ctrl_a: assert property (
        (st_reg.strapDone && p.csN) |=> st_reg.spiState == hpp_pkg::SPI_CTRL0
            && st_reg.bitCnt == hpp_pkg::BIT_FIRST
    ) else $error("released select did not end the access");

    miso_release_a: assert property (
        p.csN |=> !misoOe
    ) else $error("serial output enabled without chip select");

    ctrl_order_a: assert property (
        (byteDone && st_reg.spiState == hpp_pkg::SPI_CTRL0)
        |=> st_reg.spiState == hpp_pkg::SPI_CTRL1
    ) else $error("first control byte not followed by the second");

    strap_capture_a: assert property (
        (!st_reg.strapDone && st_reg.strapAge == hpp_pkg::STRAP_SETTLE)
        |=> st_reg.cpol == $past(dataIn[hpp_pkg::STRAP_IDLE_BIT], 3)
            && st_reg.cpha == $past(dataIn[hpp_pkg::STRAP_PHASE_BIT], 3)
            && st_reg.swap == $past(dataIn[hpp_pkg::STRAP_ORDER_BIT], 3)
    ) else $error("strap pins not captured after reset");

    miso_load_a: assert property (
        (spiActive && shiftEdge && st_reg.bitCnt == hpp_pkg::BIT_FIRST
         && st_reg.spiState == hpp_pkg::SPI_DATA && st_reg.spiRead)
        |=> misoOut == (st_reg.swap ? memRdata[0] : memRdata[hpp_pkg::DATA_W-1])
    ) else $error("read data not presented on serial output");

    serial_write_c: cover property (
        byteDone && st_reg.spiState == hpp_pkg::SPI_DATA && !st_reg.spiRead);
    serial_burst_c: cover property (
        byteDone && st_reg.spiState == hpp_pkg::SPI_DATA && st_reg.spiBurst
        ##[1:100] byteDone);
    serial_read_c: cover property (
        byteDone && st_reg.spiState == hpp_pkg::SPI_DATA && st_reg.spiRead);
    split_write_c: cover property (!p.spiSel && !p.busStyle && memReq.we);
    strobe_read_c: cover property (!p.spiSel && p.busStyle && dataOe);
endmodule

// [verification/hpp_spi_host.sv]
// serial bus master model that drives the port's serial pins
`timescale 1ns/1ps
module hpp_spi_host (
    // strap view of the expected clock
    input wire logic cpol,
    input wire logic cpha,
    // serial pins
    output logic sclk,
    output logic mosi,
    output logic csN,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        csN = 1'b1;
    end
    // clock rests at the strapped level between frames, it never runs free
    task automatic idle(input logic lvl);
        sclk = lvl;
    endtask
    task automatic select();
        csN = 1'b0;
        #400;
    endtask
    // released data line flips so a stale bit cannot pass as valid
    task automatic deselect();
        #400;
        csN = 1'b1;
        mosi = ~mosi;
        #800;
    endtask
    // one byte, tx[7] first; select stays low between bytes of an access
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        rx = '0;
        for (int i = 7; i >= 0; i--) begin
            if (!cpha) begin
                mosi = tx[i];
                #400 sclk = ~cpol;
                rx[i] = miso;
                #400 sclk = cpol;
            end else begin
                sclk = ~cpol;
                mosi = tx[i];
                #400 sclk = cpol;
                rx[i] = miso;
                #400;
            end
        end
    endtask
endmodule

// [verification/host_processor_port_tb_top.sv]
// self-checking bench for the host processor port
`timescale 1ns/1ps
module host_processor_port_tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic spiSelect = 1'b0;
    logic busStyleSelect = 1'b0;
    logic parCsN = 1'b1;
    logic readStrobeN = 1'b1;
    logic writeStrobeN = 1'b1;
    logic directionLevel = 1'b1;
    logic dataStrobeN = 1'b1;
    logic [9:0] addr = '0;
    logic [7:0] tbData = '0;
    logic [7:0] irqSources = '0;
    logic [7:0] irqEnable = '0;
    logic cpol = 1'b0;
    logic cpha = 1'b0;
    logic swap = 1'b0;
    logic [7:0] mix = '0;
    logic chipSelectN, dataOe, sclk, mosi, hostCsN, misoOut, misoOe, misoWire, intOut, intOe;
    logic [7:0] dataIn, dataOut;
    logic [7:0] expMem [1024];
    logic [7:0] ens [4] = '{8'ha5, 8'h02, 8'h80, 8'h40};
    int failures = 0;
    int testsRun = 0;

    always #50 mclk = ~mclk;
    assign chipSelectN = spiSelect ? hostCsN : parCsN;
    assign dataIn = dataOe ? dataOut : tbData;
    assign misoWire = misoOe ? misoOut : ~misoOut;

    hpp_top i_dut (.mclk(mclk), .rst(rst), .spiSelect(spiSelect),
        .busStyleSelect(busStyleSelect), .chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
        .writeStrobeN(writeStrobeN), .directionLevel(directionLevel),
        .dataStrobeN(dataStrobeN), .addrLow(addr[8:0]), .upperAddressBit(addr[9]),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .serialClock(sclk),
        .mosi(mosi), .misoOut(misoOut), .misoOe(misoOe), .irqSources(irqSources),
        .irqEnable(irqEnable), .interruptOutNOut(intOut), .interruptOutNOe(intOe));
    hpp_spi_host i_host (.cpol(cpol), .cpha(cpha), .sclk(sclk), .mosi(mosi), .csN(hostCsN),
        .miso(misoWire));

    task automatic report_and_stop();
        $display("checks %0d failures %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_oe(input logic lvl);
        int n;
        n = 0;
        while (dataOe !== lvl) begin
            @(negedge mclk);
            n++;
            if (n > 12) begin
                check("dataOe wait", {7'h0, dataOe}, {7'h0, lvl});
                report_and_stop();
            end
        end
    endtask
    // straps ride on the data bus through reset and a few edges after it
    task automatic do_reset(input logic [2:0] straps);
        @(negedge mclk);
        rst = 1'b1;
        tbData = {straps, 5'h00};
        {cpol, cpha, swap} = straps;
        i_host.idle(straps[2]);
        repeat (10) @(negedge mclk);
        check("reset enables", {5'h0, dataOe, misoOe, intOe}, 8'h00);
        rst = 1'b0;
        repeat (8) @(negedge mclk);
    endtask
    task automatic par_strobe(input logic rd, input logic low);
        if (busStyleSelect) begin
            directionLevel = rd;
            dataStrobeN = ~low;
        end else if (rd) begin
            readStrobeN = ~low;
        end else begin
            writeStrobeN = ~low;
        end
    endtask
    task automatic par_write(input logic [9:0] a, input logic [7:0] d, input logic cs);
        @(negedge mclk);
        addr = a;
        tbData = d;
        parCsN = ~cs;
        par_strobe(1'b0, 1'b1);
        repeat (6) @(negedge mclk);
        par_strobe(1'b0, 1'b0);
        repeat (4) @(negedge mclk);
        parCsN = 1'b1;
        repeat (3) @(negedge mclk);
        if (cs) expMem[a] = d;
    endtask
    task automatic par_read(input logic [9:0] a);
        @(negedge mclk);
        addr = a;
        tbData = 8'h5a;
        parCsN = 1'b0;
        par_strobe(1'b1, 1'b1);
        wait_oe(1'b1);
        repeat (3) @(negedge mclk);
        check("parallel read", dataOut, expMem[a]);
        par_strobe(1'b1, 1'b0);
        parCsN = 1'b1;
        wait_oe(1'b0);
        repeat (3) @(negedge mclk);
    endtask
    function automatic logic [13:0] rv14(input logic [13:0] v);
        logic [13:0] r;
        for (int i = 0; i < 14; i++) r[i] = v[13-i];
        return r;
    endfunction
    task automatic spi_acc(input logic rd, input logic [9:0] a, input logic burst, input int n);
        logic [13:0] f;
        logic [15:0] w;
        logic [7:0] r;
        logic [7:0] d;
        logic [13:0] t;
        f = {1'b0, a[9], 3'h0, a[8:0]};
        if (swap) f = rv14(f);
        w = {rd, f, burst};
        i_host.xfer(w[15:8], r);
        i_host.xfer(w[7:0], r);
        for (int k = 0; k < n; k++) begin
            d = rd ? 8'hff : (a[7:0] + 8'(k)) ^ mix;
            if (!rd) expMem[a + 10'(k)] = d;
            t = rv14({d, 6'h00});
            i_host.xfer(swap ? t[7:0] : d, r);
            t = rv14({r, 6'h00});
            if (rd) check("serial read", swap ? t[7:0] : r, expMem[a + 10'(k)]);
        end
    endtask

    initial begin
        do_reset(3'h0);
        for (int s = 0; s < 2; s++) begin
            busStyleSelect = s[0];
            par_write(10'h3ff, 8'hc3 ^ 8'(s), 1'b1);
            par_write(10'h1ff, 8'h3c ^ 8'(s), 1'b1);
            par_write(10'h200, 8'h96 ^ 8'(s), 1'b1);
            par_write(10'h200, 8'hee, 1'b0);
            par_read(10'h3ff);
            par_read(10'h1ff);
            par_read(10'h200);
            $display("test parallel style %0d done", s);
        end
        irqSources = 8'h5a;
        for (int k = 0; k < 4; k++) begin
            irqEnable = ens[k];
            repeat (3) @(negedge mclk);
            check("interrupt drive", {6'h0, intOut, intOe}, {7'h0, |(8'h5a & ens[k])});
        end
        $display("test interrupt done");
        spiSelect = 1'b1;
        for (int m = 0; m < 8; m++) begin
            do_reset(m[2:0]);
            mix = 8'(m * 37 + 5);
            i_host.select();
            par_strobe(1'b1, 1'b1);
            repeat (8) @(negedge mclk);
            check("serial enables", {6'h0, dataOe, misoOe}, 8'h01);
            par_strobe(1'b1, 1'b0);
            spi_acc(1'b0, 10'h100 + 10'(m * 8), 1'b1, 3);
            i_host.deselect();
            i_host.select();
            spi_acc(1'b0, 10'h240 + 10'(m), 1'b0, 1);
            spi_acc(1'b0, 10'h031 + 10'(m), 1'b0, 1);
            i_host.deselect();
            i_host.select();
            spi_acc(1'b1, 10'h240 + 10'(m), 1'b0, 1);
            spi_acc(1'b1, 10'h031 + 10'(m), 1'b0, 1);
            i_host.deselect();
            i_host.select();
            spi_acc(1'b1, 10'h100 + 10'(m * 8), 1'b1, 3);
            i_host.deselect();
            $display("test serial mode %0d done", m);
        end
        report_and_stop();
    end
endmodule
